/* File: rtl/slm_pkg.sv */
// Shared constants for the supply level monitor control block.
package slm_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [15:0] IDX_MONITOR_ENABLE = 16'h5100;
   localparam logic [15:0] IDX_THRESHOLD_SELECT = 16'h5101;
   localparam logic [15:0] IDX_MONITOR_RESULT = 16'h5102;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h5103;
   localparam logic [15:0] IDX_IRQ_MASK = 16'h5104;

   // Field positions and widths.
   localparam int DETECT_ENABLE_POS = 0;
   localparam int BELOW_FLAG_POS = 0;
   localparam int LEVEL_CODE_W = 5;

   // Values after reset.
   localparam logic DETECT_ENABLE_RESET = 1'b0;
   localparam logic BELOW_FLAG_RESET = 1'b0;
   localparam logic [4:0] LEVEL_CODE_RESET = 5'h00;

   // Valid threshold codes, 2.00 V at the low end and 3.20 V at the high end.
   localparam logic [4:0] LEVEL_CODE_MIN = 5'h0e;
   localparam logic [4:0] LEVEL_CODE_MAX = 5'h1a;

   // Interrupt event bits.
   localparam int EVT_W = 3;
   localparam int EVT_BELOW = 0;
   localparam int EVT_RECOVER = 1;
   localparam int EVT_CAPTURE = 2;
   localparam logic [2:0] IRQ_STATUS_RESET = 3'h0;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

   // Input synchroniser depth for the comparator output.
   localparam int SYNC_STAGES = 3;

endpackage : slm_pkg

/* File: rtl/slm_sync.sv */
// Three-stage input synchroniser that passes a change once two stages agree.
`timescale 1ns/1ps
module slm_sync #(
   parameter logic RESET_VALUE = 1'b0
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Asynchronous input and its clean copy.
   input wire logic async_in,
   output logic sync_out
);

   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;

   // The first stage feeds only the second, so metastability stays contained.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1_reg <= RESET_VALUE;
         stage2_reg <= RESET_VALUE;
         stage3_reg <= RESET_VALUE;
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // A change is taken only once the second and third stages agree.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_out <= RESET_VALUE;
      end else if (stage2_reg == stage3_reg) begin
         sync_out <= stage2_reg;
      end
   end

endmodule : slm_sync

/* File: rtl/slm_irq.sv */
// Sticky interrupt status with read-to-clear, a mask and one level output.
`timescale 1ns/1ps
module slm_irq #(
   parameter int EVT_W = slm_pkg::EVT_W
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Event pulses from the monitor logic.
   input wire logic [EVT_W-1:0] evt,
   // Register access.
   input wire logic status_rd,
   input wire logic mask_we,
   input wire logic [EVT_W-1:0] mask_wdata,
   output logic [EVT_W-1:0] status_reg,
   output logic [EVT_W-1:0] mask_reg,
   // Interrupt line.
   output logic irq_reg
);

   logic [EVT_W-1:0] status_next;

   // A read clears the bits it returned; an event in the same cycle stays set.
   always_comb begin
      if (status_rd) begin
         status_next = evt;
      end else begin
         status_next = status_reg | evt;
      end
   end

   // Status register.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_reg <= EVT_W'(slm_pkg::IRQ_STATUS_RESET);
      end else begin
         status_reg <= status_next;
      end
   end

   // Mask register.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_reg <= EVT_W'(slm_pkg::IRQ_MASK_RESET);
      end else if (mask_we) begin
         mask_reg <= mask_wdata;
      end
   end

   // Registered line; it lags the status register by one cycle.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_reg & mask_reg);
      end
   end

endmodule : slm_irq

/* File: rtl/slm_top.sv */
// Supply level monitor control: AHB-Lite registers, result tracking and interrupts.
//
// Notes on behaviour
// RULE1 - Writing one to the detect enable starts the comparator and the result follows it live.
// RULE2 - Writing zero to the detect enable captures the current outcome and then stops the comparator.
// RULE3 - The result reads one when the supply is below the threshold and zero otherwise.
// RULE4 - Level codes 0x0e to 0x1a select 2.00 V to 3.20 V in 0.1 V steps; other codes are reserved.
// RULE5 - Software waits the enable response time after enabling before trusting the result.
// RULE6 - Software waits the response time after changing the level before reading the result.
// RULE7 - Software clears the enable only after the response time when it wants a stable capture.
// RULE8 - Software should keep detection off when monitoring is not needed to save current.
// RULE9 - Three registers are decoded: enable at 0x5100, level at 0x5101, result at 0x5102. The code also decodes interrupt status at 0x5103 and mask at 0x5104.
// RULE10 - The enable sits in bit 0, is read and write, resets to zero, and bits 7 to 1 are reserved.
// RULE11 - The level field resets to the reserved code 0x0.
// RULE12 - Software writes zero into every reserved bit position.
// RULE13 - The result sits in bit 0, is read only, and the upper bits read as zero.
// RULE14 - While disabled the result holds its last value, and writes to it are ignored.
// RULE15 - The block drives the comparator enable and level code and synchronises its output.
`timescale 1ns/1ps
module slm_top #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 32
) (
   // Clock and reset.
   input wire logic REF_CLK,
   input wire logic RST_B,
   // AHB-Lite slave.
   input wire logic HSEL,
   input wire logic [ADDR_W-1:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [DATA_W-1:0] HWDATA,
   input wire logic HREADY,
   output logic [DATA_W-1:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Analog comparator side.
   input wire logic SUPPLY_BELOW,
   output logic SUPPLY_MON_EN,
   output logic [slm_pkg::LEVEL_CODE_W-1:0] SUPPLY_LEVEL,
   // Interrupt.
   output logic IRQ
);

   localparam int LW = slm_pkg::LEVEL_CODE_W;
   localparam int EW = slm_pkg::EVT_W;

   // Register select codes carried from address phase to data phase.
   // NONE is all zeros, so an idle data phase decodes to no register.
   typedef enum logic [2:0] {
      SLM_SEL_NONE = 3'h0,
      SLM_SEL_ENABLE = 3'h1,
      SLM_SEL_LEVEL = 3'h3,
      SLM_SEL_RESULT = 3'h2,
      SLM_SEL_STATUS = 3'h6,
      SLM_SEL_MASK = 3'h7
   } slm_sel_t;

   // True when a byte address hits the word of a register index.
   // Misaligned addresses miss every register and therefore read as zero.
   function automatic logic slm_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
      logic [ADDR_W-3:0] word;
      word = addr[ADDR_W-1:2];
      return (word == (ADDR_W-2)'(idx)) && (addr[1:0] == 2'h0);
   endfunction : slm_hit

   // Maps a byte address to the register it selects.
   function automatic slm_sel_t slm_decode(input logic [ADDR_W-1:0] addr);
      slm_sel_t sel;
      sel = SLM_SEL_NONE;
      if (slm_hit(addr, slm_pkg::IDX_MONITOR_ENABLE)) begin
         sel = SLM_SEL_ENABLE;
      end else if (slm_hit(addr, slm_pkg::IDX_THRESHOLD_SELECT)) begin
         sel = SLM_SEL_LEVEL;
      end else if (slm_hit(addr, slm_pkg::IDX_MONITOR_RESULT)) begin
         sel = SLM_SEL_RESULT;
      end else if (slm_hit(addr, slm_pkg::IDX_IRQ_STATUS)) begin
         sel = SLM_SEL_STATUS;
      end else if (slm_hit(addr, slm_pkg::IDX_IRQ_MASK)) begin
         sel = SLM_SEL_MASK;
      end
      return sel;
   endfunction : slm_decode

   // True in a write data phase aimed at the given register.
   function automatic logic slm_wr_hit(input logic active, input slm_sel_t sel,
         input slm_sel_t want);
      return active && (sel == want);
   endfunction : slm_wr_hit

   // Comparator output after the synchroniser.
   logic below_sync;

   // Bus address and data phase state.
   logic addr_take;
   slm_sel_t addr_sel;
   slm_sel_t dph_sel_reg;
   logic dph_write_reg;
   logic dph_valid_reg;
   logic wr_active;
   logic wr_enable;
   logic wr_level;
   logic wr_mask;

   // Register state and next values.
   logic enable_reg;
   logic enable_next;
   logic [LW-1:0] level_reg;
   logic [LW-1:0] level_next;
   logic result_reg;
   logic result_next;

   // Interrupt wiring and read data.
   logic [EW-1:0] evt;
   logic [EW-1:0] irq_status;
   logic [EW-1:0] irq_mask;
   logic [EW-1:0] mask_view;
   logic irq_line;
   logic status_rd;
   logic [DATA_W-1:0] rdata_next;

   // A halted comparator may chatter; the agreement test in the synchroniser keeps
   // that chatter out of the result, at the price of two more cycles of latency.
   // RULE15 comparator synchroniser
   slm_sync #(
      .RESET_VALUE(slm_pkg::BELOW_FLAG_RESET)
   ) u_below_sync (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .async_in(SUPPLY_BELOW),
      .sync_out(below_sync)
   );

   // Address phase decode; only word transfers are expected but any size is taken.
   assign addr_take = HSEL && HREADY && HTRANS[1];
   assign addr_sel = slm_decode(HADDR);

   // HREADY gates every capture, so a data phase stretched by another slave keeps
   // the transfer that it belongs to.
   // Data phase valid flag.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dph_valid_reg <= 1'b0;
      end else if (HREADY) begin
         dph_valid_reg <= addr_take;
      end
   end

   // Data phase direction.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dph_write_reg <= 1'b0;
      end else if (HREADY) begin
         dph_write_reg <= HWRITE;
      end
   end

   // Data phase register select; a cycle without a transfer selects nothing.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dph_sel_reg <= SLM_SEL_NONE;
      end else if (HREADY) begin
         dph_sel_reg <= addr_take ? addr_sel : SLM_SEL_NONE;
      end
   end

   // RULE9 write strobes
   assign wr_active = dph_valid_reg && dph_write_reg;
   assign wr_enable = slm_wr_hit(wr_active, dph_sel_reg, SLM_SEL_ENABLE);
   assign wr_level = slm_wr_hit(wr_active, dph_sel_reg, SLM_SEL_LEVEL);
   assign wr_mask = slm_wr_hit(wr_active, dph_sel_reg, SLM_SEL_MASK);

   // Reserved upper bits of the write data are dropped here.
   // RULE10 enable next value
   always_comb begin
      enable_next = enable_reg;
      if (wr_enable) begin
         enable_next = HWDATA[slm_pkg::DETECT_ENABLE_POS];
      end
   end

   // RULE1 detect enable register
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         enable_reg <= slm_pkg::DETECT_ENABLE_RESET;
      end else begin
         enable_reg <= enable_next;
      end
   end

   // Bits above the field are dropped, so reserved positions never reach the code.
   // RULE4 level code next value; reserved codes are stored as written.
   always_comb begin
      level_next = level_reg;
      if (wr_level) begin
         level_next = HWDATA[LW-1:0];
      end
   end

   // RULE11 level register reset
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         level_reg <= slm_pkg::LEVEL_CODE_RESET;
      end else begin
         level_reg <= level_next;
      end
   end

   // The result follows the comparator while enabled, and on the disabling write it
   // takes the value present in that very cycle before the enable drops.
   // Re-enabling follows the comparator at once; software waits out the response time.
   always_comb begin
      // RULE1 live follow
      // RULE2 capture on disable
      // RULE14 hold while disabled
      result_next = result_reg;
      if (enable_reg) begin
         // RULE3 one means below threshold
         result_next = below_sync;
      end
   end

   // Result register; writes to it are never decoded, so they fall away.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         result_reg <= slm_pkg::BELOW_FLAG_RESET;
      end else begin
         result_reg <= result_next;
      end
   end

   // Events: result going below, result recovering, and a capture on disable.
   always_comb begin
      evt = '0;
      // Result rose while detection runs.
      evt[slm_pkg::EVT_BELOW] = enable_reg && result_next && !result_reg;
      // Result fell while detection runs.
      evt[slm_pkg::EVT_RECOVER] = enable_reg && !result_next && result_reg;
      // Disabling write; the capture happens in this same cycle.
      evt[slm_pkg::EVT_CAPTURE] = enable_reg && !enable_next;
   end

   // A status read clears in its address phase, when the returned value is fixed.
   // An event that lands in the clearing cycle still sets its bit, so none is lost.
   assign status_rd = addr_take && !HWRITE && (addr_sel == SLM_SEL_STATUS);

   slm_irq #(
      .EVT_W(EW)
   ) u_irq (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .evt(evt),
      .status_rd(status_rd),
      .mask_we(wr_mask),
      .mask_wdata(HWDATA[EW-1:0]),
      .status_reg(irq_status),
      .mask_reg(irq_mask),
      .irq_reg(irq_line)
   );

   // A read right behind a write must see the written value, so reads use next values for every register except the status.
   assign mask_view = wr_mask ? HWDATA[EW-1:0] : irq_mask;

   // Read mux; unmapped addresses and reserved bits read as zero.
   always_comb begin
      rdata_next = '0;
      unique case (addr_sel)
         SLM_SEL_ENABLE: begin
            rdata_next[slm_pkg::DETECT_ENABLE_POS] = enable_next;
         end
         SLM_SEL_LEVEL: begin
            rdata_next[LW-1:0] = level_next;
         end
         SLM_SEL_RESULT: begin
            // RULE13 result bit only
            rdata_next[slm_pkg::BELOW_FLAG_POS] = result_next;
         end
         SLM_SEL_STATUS: begin
            rdata_next[EW-1:0] = irq_status;
         end
         SLM_SEL_MASK: begin
            rdata_next[EW-1:0] = mask_view;
         end
         SLM_SEL_NONE: begin
            rdata_next = '0;
         end
      endcase
   end

   // Read data register, loaded at the end of a read address phase.
   // Loading it there keeps the data phase free of wait states, at the cost of a
   // read mux that must see the next values of the registers.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         HRDATA <= '0;
      end else if (addr_take && !HWRITE) begin
         HRDATA <= rdata_next;
      end
   end

   // The slave never inserts wait states.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         HREADYOUT <= 1'b1;
      end else begin
         HREADYOUT <= 1'b1;
      end
   end

   // Every transfer is answered OKAY, unmapped ones included.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         HRESP <= 1'b0;
      end else begin
         HRESP <= 1'b0;
      end
   end

   // The pin copies the enable register, so the comparator stops at the disabling edge.
   // RULE15 comparator enable drive
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SUPPLY_MON_EN <= slm_pkg::DETECT_ENABLE_RESET;
      end else begin
         SUPPLY_MON_EN <= enable_next;
      end
   end

   // RULE15 level code drive; a reserved code reaches the analog side unchanged.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SUPPLY_LEVEL <= slm_pkg::LEVEL_CODE_RESET;
      end else begin
         SUPPLY_LEVEL <= level_next;
      end
   end

   // Interrupt output straight from the interrupt block's flop, re-timed here.
   // The extra cycle of latency is harmless for a level line that stays up until read.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= irq_line;
      end
   end

endmodule : slm_top

/* File: verif/slm_top_props.sv */
// Concurrent checks on the ports of the supply level monitor control block.
`timescale 1ns/1ps
module slm_top_props #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 32
) (
   // Clock and reset.
   input wire logic REF_CLK,
   input wire logic RST_B,
   // Bus.
   input wire logic HSEL,
   input wire logic [ADDR_W-1:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [DATA_W-1:0] HWDATA,
   input wire logic HREADY,
   input wire logic [DATA_W-1:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   // Analog side and interrupt.
   input wire logic SUPPLY_BELOW,
   input wire logic SUPPLY_MON_EN,
   input wire logic [slm_pkg::LEVEL_CODE_W-1:0] SUPPLY_LEVEL,
   input wire logic IRQ
);
   localparam logic [ADDR_W-1:0] A_EN = ADDR_W'({slm_pkg::IDX_MONITOR_ENABLE, 2'b00});
   localparam logic [ADDR_W-1:0] A_LVL = ADDR_W'({slm_pkg::IDX_THRESHOLD_SELECT, 2'b00});
   localparam logic [ADDR_W-1:0] A_RES = ADDR_W'({slm_pkg::IDX_MONITOR_RESULT, 2'b00});
   localparam logic [ADDR_W-1:0] A_MASK = ADDR_W'({slm_pkg::IDX_IRQ_MASK, 2'b00});
   logic take;
   logic ph_wr_en, ph_wr_lvl, ph_rd_en, ph_rd_lvl, ph_rd_res, ph_rd_bad;

   // An address phase is taken only when selected, ready and active.
   assign take = HSEL & HREADY & HTRANS[1];

   // Remember which register the following data phase belongs to.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ph_wr_en <= 1'b0;
         ph_wr_lvl <= 1'b0;
         ph_rd_en <= 1'b0;
         ph_rd_lvl <= 1'b0;
         ph_rd_res <= 1'b0;
         ph_rd_bad <= 1'b0;
      end else begin
         ph_wr_en <= take & HWRITE & (HADDR == A_EN);
         ph_wr_lvl <= take & HWRITE & (HADDR == A_LVL);
         ph_rd_en <= take & !HWRITE & (HADDR == A_EN);
         ph_rd_lvl <= take & !HWRITE & (HADDR == A_LVL);
         ph_rd_res <= take & !HWRITE & (HADDR == A_RES);
         ph_rd_bad <= take & !HWRITE & (HADDR > A_MASK);
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);

   AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
      else $error("bus answer not ready or not okay");
   AST_EN_WRITE: assert property (ph_wr_en |=> SUPPLY_MON_EN == $past(HWDATA[0]))
      else $error("comparator enable does not follow the written bit");
   AST_LVL_WRITE: assert property (ph_wr_lvl |=> SUPPLY_LEVEL == $past(HWDATA[4:0]))
      else $error("level code does not follow the written field");
   AST_EN_HOLD: assert property (!ph_wr_en |=> $stable(SUPPLY_MON_EN))
      else $error("comparator enable moved without a write");
   AST_LVL_HOLD: assert property (!ph_wr_lvl |=> $stable(SUPPLY_LEVEL))
      else $error("level code moved without a write");
   AST_EN_READ: assert property (ph_rd_en |-> HRDATA == DATA_W'(SUPPLY_MON_EN))
      else $error("enable read differs from the enable output");
   AST_LVL_READ: assert property (ph_rd_lvl |-> HRDATA == DATA_W'(SUPPLY_LEVEL))
      else $error("level read differs from the level output");
   AST_RES_UPPER: assert property (ph_rd_res |-> HRDATA[DATA_W-1:1] == '0)
      else $error("result upper bits not zero");
   AST_UNMAPPED: assert property (ph_rd_bad |-> HRDATA == '0)
      else $error("unmapped read not zero");
endmodule : slm_top_props

bind slm_top slm_top_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_slm_top_props (
   .REF_CLK(REF_CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SUPPLY_BELOW(SUPPLY_BELOW),
   .SUPPLY_MON_EN(SUPPLY_MON_EN), .SUPPLY_LEVEL(SUPPLY_LEVEL), .IRQ(IRQ));

/* File: verif/slm_cmp_model.sv */
// Behavioural supply comparator that drives the below-threshold flag.
`timescale 1ns/1ps
module slm_cmp_model (
   // Clock that paces the idle pattern.
   input wire logic clk,
   // Controls from the block.
   input wire logic en,
   input wire logic [4:0] level,
   // Supply in millivolts and the comparator output.
   input wire logic [15:0] vdd_mv,
   output logic below
);
   int thr;

   assign thr = 2000 + 100 * (int'(level) - 14);

   initial below = 1'b0;

   // threshold compare
   // A halted or misprogrammed comparator has no valid answer, so it toggles to expose misuse.
   always @(posedge clk) begin
      if (en && level >= 5'h0e && level <= 5'h1a) begin
         below <= (int'(vdd_mv) < thr);
      end else begin
         below <= ~below;
      end
   end
endmodule : slm_cmp_model

/* File: verif/test_supply_level_monitor_ctrl.sv */
// Self-checking bench for the supply level monitor control block.
`timescale 1ns/1ps
module test_supply_level_monitor_ctrl;
   logic REF_CLK, RST_B, HSEL, HWRITE, HREADY, SUPPLY_BELOW, SUPPLY_MON_EN;
   logic HREADYOUT, HRESP, IRQ;
   logic [19:0] HADDR;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic [31:0] HWDATA, HRDATA, rd;
   logic [4:0] SUPPLY_LEVEL;
   int vdd, m_res, seed = 46, num_errors = 0, tests_run = 0, cyc = 0;

   // The single slave's ready is the bus ready.
   assign HREADY = HREADYOUT;

   slm_top u_slm_top (.REF_CLK(REF_CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SUPPLY_BELOW(SUPPLY_BELOW),
      .SUPPLY_MON_EN(SUPPLY_MON_EN), .SUPPLY_LEVEL(SUPPLY_LEVEL), .IRQ(IRQ));

   slm_cmp_model u_slm_cmp_model (.clk(REF_CLK), .en(SUPPLY_MON_EN), .level(SUPPLY_LEVEL),
      .vdd_mv(vdd[15:0]), .below(SUPPLY_BELOW));

   // Free-running clock.
   initial begin
      REF_CLK = 1'b0;
      forever #5 REF_CLK = ~REF_CLK;
   end

   task automatic results;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One single transfer; the master waits for ready, however long that takes.
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HADDR <= {2'b00, idx, 2'b00};
      HWRITE <= wr;
      do @(posedge REF_CLK); while (HREADY !== 1'b1);
      HTRANS <= 2'b00;
      HSEL <= 1'b0;
      HWDATA <= wd;
      do @(posedge REF_CLK); while (HREADY !== 1'b1);
      rd = HRDATA;
   endtask : bus

   task automatic rchk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(nm, exp, rd);
   endtask : rchk

   task automatic wt(input int n);
      repeat (n) @(posedge REF_CLK);
   endtask : wt

   // A hang is cut short and counted as a mismatch.
   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         results();
      end
   end

   // Main sequence.
   initial begin
      RST_B = 1'b0;
      HSEL = 1'b0;
      HADDR = 20'h0;
      HTRANS = 2'b00;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = 32'h0;
      vdd = 2500;
      wt(20);
      RST_B <= 1'b1;
      wt(1);
      rchk("enable", slm_pkg::IDX_MONITOR_ENABLE, 32'h0);
      rchk("level", slm_pkg::IDX_THRESHOLD_SELECT, 32'h0);
      rchk("result", slm_pkg::IDX_MONITOR_RESULT, 32'h0);
      rchk("mask", slm_pkg::IDX_IRQ_MASK, 32'h0);
      rchk("status", slm_pkg::IDX_IRQ_STATUS, 32'h0);
      bus(1'b1, slm_pkg::IDX_MONITOR_RESULT, 32'h1);
      rchk("result", slm_pkg::IDX_MONITOR_RESULT, 32'h0);
      bus(1'b1, 16'h5106, 32'h1);
      rchk("unmapped", 16'h5106, 32'h0);
      bus(1'b1, slm_pkg::IDX_THRESHOLD_SELECT, 32'h1f);
      rchk("level", slm_pkg::IDX_THRESHOLD_SELECT, 32'h1f);
      bus(1'b1, slm_pkg::IDX_MONITOR_ENABLE, 32'h1);
      rchk("enable", slm_pkg::IDX_MONITOR_ENABLE, 32'h1);
      // Every valid code against a random supply, waiting out the response time.
      for (int c = 14; c <= 26; c++) begin
         vdd = 1900 + int'($unsigned($random(seed)) % 1400);
         bus(1'b1, slm_pkg::IDX_THRESHOLD_SELECT, 32'(c));
         wt(10);
         m_res = (vdd < 2000 + (c - 14) * 100) ? 1 : 0;
         chk("level_pins", 32'(c), {27'h0, SUPPLY_LEVEL});
         rchk("result", slm_pkg::IDX_MONITOR_RESULT, 32'(m_res));
      end
      // Boundary at the top level and the rise and fall events.
      vdd = 3200;
      wt(10);
      bus(1'b0, slm_pkg::IDX_IRQ_STATUS, 32'h0);
      rchk("result", slm_pkg::IDX_MONITOR_RESULT, 32'h0);
      vdd = 3199;
      wt(10);
      rchk("status", slm_pkg::IDX_IRQ_STATUS, 32'h1);
      rchk("result", slm_pkg::IDX_MONITOR_RESULT, 32'h1);
      vdd = 3200;
      wt(10);
      rchk("status", slm_pkg::IDX_IRQ_STATUS, 32'h2);
      // Capture on disable with the capture event unmasked.
      bus(1'b1, slm_pkg::IDX_IRQ_MASK, 32'h4);
      rchk("mask", slm_pkg::IDX_IRQ_MASK, 32'h4);
      vdd = 3000;
      wt(10);
      bus(1'b0, slm_pkg::IDX_IRQ_STATUS, 32'h0);
      bus(1'b1, slm_pkg::IDX_MONITOR_ENABLE, 32'h0);
      wt(1);
      chk("mon_en", 32'h0, {31'h0, SUPPLY_MON_EN});
      vdd = 3300;
      wt(4);
      chk("irq", 32'h1, {31'h0, IRQ});
      wt(10);
      rchk("result", slm_pkg::IDX_MONITOR_RESULT, 32'h1);
      rchk("status", slm_pkg::IDX_IRQ_STATUS, 32'h4);
      wt(4);
      chk("irq", 32'h0, {31'h0, IRQ});
      // Masked capture leaves the line low but still records the event.
      bus(1'b1, slm_pkg::IDX_IRQ_MASK, 32'h0);
      bus(1'b1, slm_pkg::IDX_MONITOR_ENABLE, 32'h1);
      wt(10);
      rchk("result", slm_pkg::IDX_MONITOR_RESULT, 32'h0);
      bus(1'b1, slm_pkg::IDX_MONITOR_ENABLE, 32'h0);
      wt(4);
      chk("irq", 32'h0, {31'h0, IRQ});
      bus(1'b0, slm_pkg::IDX_IRQ_STATUS, 32'h0);
      chk("status_capture", 32'h1, {31'h0, rd[2]});
      results();
   end
endmodule : test_supply_level_monitor_ctrl
